// *** design/dsc_regs.svh ***
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
// How it works
// - 32-bit frame, msb first, fields fixed
// - execute command on 32nd falling clock
// - codes 0-3 write/update input and dac
// - codes 4-8 control, 9-15 reserved
// - address 0-7 one channel, 15 all
// - early frame rise discards whole frame
// - command 8 bit 0 sets reference
// - outputs zero until first complete frame
// - command 7 restores power-on state
// - strobe and clear ignored during power-on
// - command 4 applies mode to masked channels
// - modes: normal, 1k, 100k, three-state
// - with reference on, only all-channel powerdown
// - reference off when disabled or all down
// - power-up takes input value if strobe low
// - clear falling edge loads clear code
// - command 5 stores clear code select
// - cleared state ends at next frame
// - clear during a frame aborts it
// - line one low group, line two high
// - shift on falling clock while line low
// - command 6 loads per-channel load mask
// - clear codes 0, 0x800, 0xFFF, none

// ---------------------------------------------
// frame fields
// ---------------------------------------------
`define DSC_FRAME_BITS 6'h20
`define DSC_LAST_BIT 6'h1F
`define DSC_CMD_HI 27
`define DSC_CMD_LO 24
`define DSC_ADDR_HI 23
`define DSC_ADDR_LO 20
`define DSC_DATA_HI 19
`define DSC_DATA_LO 8
`define DSC_PD_HI 9
`define DSC_PD_LO 8
`define DSC_MASK_HI 7
`define DSC_MASK_LO 0
`define DSC_CLRSEL_HI 1
`define DSC_CLRSEL_LO 0
`define DSC_REF_BIT 0
`define DSC_ADDR_ALL 4'hF

// ---------------------------------------------
// reset values and codes
// ---------------------------------------------
`define DSC_PIN_IDLE 6'h2F
`define DSC_CODE_ZERO 12'h000
`define DSC_CODE_MID 12'h800
`define DSC_CODE_FULL 12'hFFF
`define DSC_MASK_ALL 8'hFF
`define DSC_MASK_NONE 8'h00
`define DSC_MASK_ONE 8'h01
`define DSC_PD_NORMAL 2'h0
`define DSC_CLRSEL_RST 2'h0
`define DSC_CLRSEL_NOP 2'h3
`define DSC_REF_RST 1'h0
`endif

// *** design/dsc_pkg.sv ***
package dsc_pkg;
   // command codes carried in the command field
   typedef enum logic [3:0] {
      DSC_WR_IN = 4'b0000,
      DSC_UPD_DAC = 4'b0001,
      DSC_WR_IN_UPD_ALL = 4'b0010,
      DSC_WR_UPD = 4'b0011,
      DSC_POWER = 4'b0100,
      DSC_LD_CLR = 4'b0101,
      DSC_LD_MASK = 4'b0110,
      DSC_SW_RESET = 4'b0111,
      DSC_SET_REF = 4'b1000
   } dsc_cmd_t;
   // output stage modes
   typedef enum logic [1:0] {
      DSC_PD_RUN = 2'b00,
      DSC_PD_1K = 2'b01,
      DSC_PD_100K = 2'b10,
      DSC_PD_TRI = 2'b11
   } dsc_pd_t;
endpackage

// *** design/dsc_decoder.sv ***
`timescale 1ns/10ps
`include "dsc_regs.svh"
module dsc_decoder import dsc_pkg::*; (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   // serial pins from the host
   input wire logic dac_serial_clock,
   input wire logic dac_serial_input,
   input wire logic frame_select_low_group_n,
   input wire logic frame_select_high_group_n,
   // hardware pins
   input wire logic load_outputs_strobe_n,
   input wire logic clear_outputs_pin_n,
   // per-channel output state, channel c at [12*c +: 12] and [2*c +: 2]
   output logic [191:0] channel_code,
   output logic [31:0] channel_mode,
   // per-group status, bit 0 low group, bit 1 high group
   output logic [1:0] internal_reference_enable,
   output logic [1:0] reference_on,
   output logic [1:0] clear_active,
   output logic [1:0] output_hold
);

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic [5:0] pin_raw;
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic [5:0] pin_prev;
   logic sclk_fall;
   logic strobe_fall;
   logic strobe_low;
   logic clr_fall;
   logic sdi;

   assign pin_raw = {dac_serial_clock, dac_serial_input, frame_select_low_group_n,
                     frame_select_high_group_n, load_outputs_strobe_n, clear_outputs_pin_n};

   // two flops before any logic, a third only for edge detection
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta <= `DSC_PIN_IDLE;
         pin_sync <= `DSC_PIN_IDLE;
         pin_prev <= `DSC_PIN_IDLE;
      end else if (clk_en) begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // edges seen in the system clock; the serial clock must stay well below half the sample rate
   assign sclk_fall = pin_prev[5] & ~pin_sync[5];
   assign sdi = pin_sync[4];
   assign strobe_fall = pin_prev[1] & ~pin_sync[1];
   assign strobe_low = ~pin_sync[1];
   assign clr_fall = pin_prev[0] & ~pin_sync[0];

   // ---------------------------------------------
   // one decoder per eight-channel group
   // ---------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : grp
         logic frame_n;
         logic [31:0] shift;
         logic [5:0] cnt;
         logic aborted;
         logic exec;
         logic [31:0] word;
         logic [3:0] cmd;
         logic [3:0] addr;
         logic [11:0] data;
         logic [7:0] sel;
         logic [7:0] upd_mask;
         logic [11:0] clr_code;
         logic clr_hit;
         logic pd_ok;
         logic all_down;
         logic por_hold;
         logic ref_en;
         logic cleared;
         logic [1:0] clr_sel;
         logic [7:0] load_outputs_strobe_mask;
         logic [11:0] in_reg [8];
         logic [11:0] dac_reg [8];
         logic [1:0] pd_mode [8];
         // group copies of the outputs; each group drives only its own slice
         logic [95:0] grp_code;
         logic [15:0] grp_mode;
         logic grp_ref;
         logic grp_ref_on;
         logic grp_clear;
         logic grp_hold;

         // low group answers the first line, high group the second
         assign frame_n = pin_sync[3 - g];

         // ---------------------------------------------
         // frame capture
         // ---------------------------------------------
         assign word = {shift[30:0], sdi};
         // an honoured clear wins over the last bit; one ignored during hold lets the frame finish
         assign exec = sclk_fall & ~frame_n & ~aborted & (cnt == `DSC_LAST_BIT) & ~(clr_fall & ~por_hold);
         assign cmd = word[`DSC_CMD_HI:`DSC_CMD_LO];
         assign addr = word[`DSC_ADDR_HI:`DSC_ADDR_LO];
         assign data = word[`DSC_DATA_HI:`DSC_DATA_LO];

         // rising line before the last bit drops everything; extra clocks after 32 are ignored
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               shift <= 32'h0000_0000;
               cnt <= 6'h00;
               aborted <= 1'b0;
            end else if (clk_en) begin
               if (frame_n) begin
                  shift <= 32'h0000_0000;
                  cnt <= 6'h00;
                  aborted <= 1'b0;
               end else if (clr_fall && !por_hold) begin
                  shift <= 32'h0000_0000;
                  cnt <= 6'h00;
                  aborted <= 1'b1;
               end else if (sclk_fall && !aborted && cnt != `DSC_FRAME_BITS) begin
                  shift <= word;
                  cnt <= cnt + 6'h01;
               end
            end
         end

         // ---------------------------------------------
         // command decode
         // ---------------------------------------------
         always_comb begin
            if (addr == `DSC_ADDR_ALL) begin
               sel = `DSC_MASK_ALL;
            end else if (addr[3]) begin
               sel = `DSC_MASK_NONE;
            end else begin
               sel = `DSC_MASK_ONE << addr[2:0];
            end
         end

         // a channel updates now if its mask bit is set or the strobe is held low
         assign upd_mask = sel & (load_outputs_strobe_mask | {8{strobe_low}});
         // with the reference running, a partial power-down is refused
         assign pd_ok = !ref_en || (word[`DSC_MASK_HI:`DSC_MASK_LO] == `DSC_MASK_ALL);

         always_comb begin
            case (clr_sel)
               2'h0: clr_code = `DSC_CODE_ZERO;
               2'h1: clr_code = `DSC_CODE_MID;
               2'h2: clr_code = `DSC_CODE_FULL;
               default: clr_code = `DSC_CODE_ZERO;
            endcase
         end
         // pin events are ignored until power-on hold ends; select 3 is no operation
         assign clr_hit = clr_fall & ~por_hold & (clr_sel != `DSC_CLRSEL_NOP);

         // ---------------------------------------------
         // control registers
         // ---------------------------------------------
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               por_hold <= 1'b1;
               ref_en <= `DSC_REF_RST;
               clr_sel <= `DSC_CLRSEL_RST;
               load_outputs_strobe_mask <= `DSC_MASK_NONE;
               cleared <= 1'b0;
            end else if (clk_en) begin
               if (exec && cmd == DSC_SW_RESET) begin
                  por_hold <= 1'b1;
                  ref_en <= `DSC_REF_RST;
                  clr_sel <= `DSC_CLRSEL_RST;
                  load_outputs_strobe_mask <= `DSC_MASK_NONE;
                  cleared <= 1'b0;
               end else begin
                  if (exec) begin
                     por_hold <= 1'b0;
                     cleared <= 1'b0;
                  end else if (clr_hit) begin
                     cleared <= 1'b1;
                  end
                  if (exec && cmd == DSC_SET_REF) begin
                     ref_en <= word[`DSC_REF_BIT];
                  end
                  if (exec && cmd == DSC_LD_CLR) begin
                     clr_sel <= word[`DSC_CLRSEL_HI:`DSC_CLRSEL_LO];
                  end
                  if (exec && cmd == DSC_LD_MASK) begin
                     load_outputs_strobe_mask <= word[`DSC_MASK_HI:`DSC_MASK_LO];
                  end
               end
            end
         end

         // ---------------------------------------------
         // channel registers
         // ---------------------------------------------
         // clear wins over everything; a frame never executes in the clear cycle
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               for (int c = 0; c < 8; c++) begin
                  in_reg[c] <= `DSC_CODE_ZERO;
                  dac_reg[c] <= `DSC_CODE_ZERO;
                  pd_mode[c] <= `DSC_PD_NORMAL;
               end
            end else if (clk_en) begin
               for (int c = 0; c < 8; c++) begin
                  if (clr_hit) begin
                     in_reg[c] <= clr_code;
                     dac_reg[c] <= clr_code;
                  end else if (exec && cmd == DSC_SW_RESET) begin
                     in_reg[c] <= `DSC_CODE_ZERO;
                     dac_reg[c] <= `DSC_CODE_ZERO;
                     pd_mode[c] <= `DSC_PD_NORMAL;
                  end else if (exec) begin
                     // codes 4-8 also act on the control registers; 9-15 fall through untouched
                     case (cmd)
                        DSC_WR_IN: begin
                           if (sel[c]) in_reg[c] <= data;
                           if (upd_mask[c]) dac_reg[c] <= data;
                        end
                        DSC_UPD_DAC: begin
                           if (sel[c]) dac_reg[c] <= in_reg[c];
                        end
                        DSC_WR_IN_UPD_ALL: begin
                           if (sel[c]) begin
                              in_reg[c] <= data;
                              dac_reg[c] <= data;
                           end else begin
                              dac_reg[c] <= in_reg[c];
                           end
                        end
                        DSC_WR_UPD: begin
                           if (sel[c]) begin
                              in_reg[c] <= data;
                              dac_reg[c] <= data;
                           end
                        end
                        DSC_POWER: begin
                           if (pd_ok && word[`DSC_MASK_LO + c]) begin
                              pd_mode[c] <= word[`DSC_PD_HI:`DSC_PD_LO];
                              // dac register is kept while down; power-up may take the input value
                              if (word[`DSC_PD_HI:`DSC_PD_LO] == `DSC_PD_NORMAL && pd_mode[c] != `DSC_PD_NORMAL
                                  && strobe_low) begin
                                 dac_reg[c] <= in_reg[c];
                              end
                           end
                        end
                        default: begin
                        end
                     endcase
                  end else if (strobe_fall && !por_hold && !load_outputs_strobe_mask[c]) begin
                     dac_reg[c] <= in_reg[c];
                  end
               end
            end
         end

         // ---------------------------------------------
         // outputs
         // ---------------------------------------------
         always_comb begin
            all_down = 1'b1;
            for (int c = 0; c < 8; c++) begin
               if (pd_mode[c] == `DSC_PD_NORMAL) all_down = 1'b0;
            end
         end

         // zero while held or powered down; the mode output tells the pad what to connect
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               for (int c = 0; c < 8; c++) begin
                  grp_code[c * 12 +: 12] <= `DSC_CODE_ZERO;
                  grp_mode[c * 2 +: 2] <= `DSC_PD_NORMAL;
               end
               grp_ref <= `DSC_REF_RST;
               grp_ref_on <= 1'b0;
               grp_clear <= 1'b0;
               grp_hold <= 1'b1;
            end else if (clk_en) begin
               for (int c = 0; c < 8; c++) begin
                  grp_code[c * 12 +: 12] <= (por_hold || pd_mode[c] != `DSC_PD_NORMAL)
                     ? `DSC_CODE_ZERO : dac_reg[c];
                  grp_mode[c * 2 +: 2] <= pd_mode[c];
               end
               grp_ref <= ref_en;
               grp_ref_on <= ref_en & ~all_down;
               grp_clear <= cleared;
               grp_hold <= por_hold;
            end
         end

         // one writer per slice: two group processes must never share an output variable
         assign channel_code[96 * g +: 96] = grp_code;
         assign channel_mode[16 * g +: 16] = grp_mode;
         assign internal_reference_enable[g] = grp_ref;
         assign reference_on[g] = grp_ref_on;
         assign clear_active[g] = grp_clear;
         assign output_hold[g] = grp_hold;
      end
   endgenerate

endmodule // dsc_decoder

// *** verif/dsc_checker_assertions.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// port checker for the serial command decoder
// ----------------------------------------
module dsc_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // host pins
   input wire logic frame_select_low_group_n,
   input wire logic frame_select_high_group_n,
   input wire logic load_outputs_strobe_n,
   input wire logic clear_outputs_pin_n,
   // decoder outputs
   input wire logic [191:0] channel_code,
   input wire logic [31:0] channel_mode,
   input wire logic [1:0] internal_reference_enable,
   input wire logic [1:0] reference_on,
   input wire logic [1:0] clear_active,
   input wire logic [1:0] output_hold
);
   logic [1:0] all_down;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // group flag: every channel of the group in a powered-down mode
   always_comb begin
      all_down = 2'b11;
      for (int c = 0; c < 16; c++) begin
         if (channel_mode[2*c +: 2] == 2'h0) begin
            all_down[c/8] = 1'b0;
         end
      end
   end
   // eight quiet cycles on both frame lines, strobe and clear; late frame results have landed by then
   sequence s_pins_quiet;
      (frame_select_low_group_n && frame_select_high_group_n && clear_outputs_pin_n
         && load_outputs_strobe_n) [*8];
   endsequence
   sequence s_ref_off_twice;
      !internal_reference_enable[0] ##1 !internal_reference_enable[0];
   endsequence
   a_quiet_no_change: assert property (s_pins_quiet |-> $stable(channel_code) && $stable(channel_mode))
      else $error("outputs changed with no pin activity");
   a_reset_state_ok: assert property ($rose(rstn) |-> channel_code == '0 && output_hold == 2'b11
      && internal_reference_enable == 2'b00) else $error("bad state after reset");
   a_hold_low_zero: assert property (output_hold[0] |-> channel_code[95:0] == '0)
      else $error("low group code not zero while held");
   a_hold_high_zero: assert property (output_hold[1] |-> channel_code[191:96] == '0)
      else $error("high group code not zero while held");
   a_hold_blocks_clear: assert property (output_hold[0] |-> !clear_active[0])
      else $error("clear taken during power-on hold");
   a_ref_needs_enable: assert property (s_ref_off_twice |-> !reference_on[0])
      else $error("reference on while disabled");
   a_all_down_ref: assert property (all_down[0] ##1 all_down[0] |-> !reference_on[0])
      else $error("reference on with all channels down");
   a_down_code_zero: assert property (channel_mode[7:6] != 2'h0 ##1 channel_mode[7:6] != 2'h0
      |-> channel_code[47:36] == 12'h000) else $error("powered-down channel drives a code");
   a_ref_all_modes: assert property ($changed(channel_mode[15:0]) && $past(internal_reference_enable[0])
      && internal_reference_enable[0] |-> channel_mode[15:0] == {8{channel_mode[1:0]}})
      else $error("partial power-down with reference on");
endmodule // dsc_checker

bind dsc_decoder dsc_checker u_dsc_checker (.*);

// *** verif/dsc_host.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// host serial master model
// ----------------------------------------
module dsc_host (
   // system clock
   input wire logic clk,
   // serial link
   output logic dac_serial_clock,
   output logic dac_serial_input,
   output logic frame_select_low_group_n,
   output logic frame_select_high_group_n,
   // hardware pins
   output logic load_outputs_strobe_n,
   output logic clear_outputs_pin_n
);
   // idle levels: serial clock parked high, both lines deselected
   initial begin
      dac_serial_clock = 1'b1;
      dac_serial_input = 1'b0;
      frame_select_low_group_n = 1'b1;
      frame_select_high_group_n = 1'b1;
      load_outputs_strobe_n = 1'b1;
      clear_outputs_pin_n = 1'b1;
   end
   // frame of n bits, five clocks per half period; clear pulsed at bit clr_at
   task automatic frame(input logic [1:0] sel, input logic [3:0] cmd, input logic [3:0] adr,
      input logic [11:0] dat, input logic [7:0] lo, input int n, input int clr_at);
      logic [31:0] word;
      word = {4'h0, cmd, adr, dat, lo};
      @(posedge clk);
      frame_select_low_group_n <= !sel[0];
      frame_select_high_group_n <= !sel[1];
      for (int k = 0; k < n; k++) begin
         dac_serial_input <= word[31-k];
         repeat (5) @(posedge clk);
         dac_serial_clock <= 1'b0;
         clear_outputs_pin_n <= (k != clr_at);
         repeat (5) @(posedge clk);
         dac_serial_clock <= 1'b1;
      end
      repeat (5) @(posedge clk);
      clear_outputs_pin_n <= 1'b1;
      dac_serial_input <= !dac_serial_input; // released line must not look held
      frame_select_low_group_n <= 1'b1;
      frame_select_high_group_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   // strobe (0) or clear pin (1) low for six clocks
   task automatic pulse(input logic is_clr);
      @(posedge clk);
      load_outputs_strobe_n <= is_clr;
      clear_outputs_pin_n <= !is_clr;
      repeat (6) @(posedge clk);
      load_outputs_strobe_n <= 1'b1;
      clear_outputs_pin_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
endmodule // dsc_host

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// decoder testbench
// ----------------------------------------
module tb_top;
   import dsc_pkg::*;
   logic clk, rstn, clk_en, dac_serial_clock, dac_serial_input;
   logic frame_select_low_group_n, frame_select_high_group_n, load_outputs_strobe_n, clear_outputs_pin_n;
   logic [191:0] channel_code;
   logic [31:0] channel_mode;
   logic [1:0] internal_reference_enable, reference_on, clear_active, output_hold;
   int err_total = 0;
   int check_count = 0;
   dsc_decoder u_dsc_decoder (.*);
   dsc_host u_dsc_host (.*);
   // compare and count
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [11:0] cc(input int c);
      return channel_code[12*c +: 12];
   endfunction
   task automatic wr(input logic [1:0] sel, input logic [3:0] cmd, input logic [3:0] adr,
      input logic [11:0] dat, input logic [7:0] lo);
      u_dsc_host.frame(sel, cmd, adr, dat, lo, 32, -1);
   endtask
   task automatic tally_and_finish;
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // run is about 11k clocks; cut a hang well past that
   initial begin
      #400000;
      err_total++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      rstn = 1'b0;
      clk_en = 1'b1;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      chk(12'(output_hold), 12'h003);
      wr(2'b01, DSC_WR_UPD, 4'h3, 12'hABC, 8'h00);
      chk(cc(3), 12'hABC);
      chk(12'(output_hold), 12'h002);
      u_dsc_host.frame(2'b01, DSC_WR_UPD, 4'h3, 12'h111, 8'h00, 20, -1);
      chk(cc(3), 12'hABC);
      wr(2'b10, DSC_WR_UPD, 4'hF, 12'h123, 8'h00);
      chk(cc(15), 12'h123);
      chk(cc(3), 12'hABC);
      wr(2'b11, DSC_WR_UPD, 4'h1, 12'h456, 8'h00);
      chk(cc(9), 12'h456);
      chk(cc(1), 12'h456);
      wr(2'b01, DSC_WR_IN, 4'h5, 12'h5A5, 8'h00);
      chk(cc(5), 12'h000);
      wr(2'b01, DSC_UPD_DAC, 4'h5, 12'h000, 8'h00);
      chk(cc(5), 12'h5A5);
      wr(2'b01, DSC_WR_IN, 4'h6, 12'h666, 8'h00);
      u_dsc_host.pulse(1'b0);
      chk(cc(6), 12'h666);
      wr(2'b01, DSC_LD_MASK, 4'h0, 12'h000, 8'h80);
      wr(2'b01, DSC_WR_IN, 4'h7, 12'h777, 8'h00);
      chk(cc(7), 12'h777);
      wr(2'b01, DSC_WR_IN, 4'h0, 12'h0F0, 8'h00);
      wr(2'b01, DSC_WR_IN_UPD_ALL, 4'h2, 12'h222, 8'h00);
      chk(cc(0), 12'h0F0);
      for (int c = 9; c < 16; c++) begin
         wr(2'b01, 4'(c), 4'h2, 12'hEEE, 8'h00);
         chk(cc(2), 12'h222);
      end
      wr(2'b01, DSC_SET_REF, 4'h0, 12'h000, 8'h01);
      chk(12'(reference_on), 12'h001);
      wr(2'b01, DSC_POWER, 4'h0, 12'h003, 8'h01);
      chk(12'(channel_mode[15:0]), 12'h000);
      wr(2'b01, DSC_WR_IN, 4'h6, 12'h999, 8'h00);
      // modes 1..3 then back to normal; channel 6 input differs from its output
      for (int m = 1; m < 5; m++) begin
         wr(2'b01, DSC_POWER, 4'h0, 12'(m % 4), 8'hFF);
         chk(12'(channel_mode[15:14]), 12'(m % 4));
         chk(cc(6), (m < 4) ? 12'h000 : 12'h666);
         chk(12'(reference_on[0]), (m < 4) ? 12'h000 : 12'h001);
      end
      wr(2'b01, DSC_LD_CLR, 4'h0, 12'h000, 8'h01);
      u_dsc_host.pulse(1'b1);
      chk(cc(3), 12'h800);
      chk(cc(12), 12'h000);
      chk(12'(clear_active), 12'h003);
      u_dsc_host.frame(2'b01, DSC_WR_UPD, 4'h4, 12'h321, 8'h00, 32, 10);
      chk(cc(4), 12'h800);
      wr(2'b01, DSC_WR_UPD, 4'h4, 12'h432, 8'h00);
      chk(12'(clear_active), 12'h002);
      wr(2'b01, DSC_LD_CLR, 4'h0, 12'h000, 8'h03);
      wr(2'b10, DSC_LD_CLR, 4'h0, 12'h000, 8'h02);
      u_dsc_host.pulse(1'b1);
      chk(cc(4), 12'h432);
      chk(cc(12), 12'hFFF);
      // enable held low: a whole frame to the high group must go unseen
      clk_en <= 1'b0;
      wr(2'b10, DSC_WR_UPD, 4'hF, 12'h5A5, 8'h00);
      clk_en <= 1'b1;
      chk(cc(12), 12'hFFF);
      chk(12'(clear_active), 12'h002);
      wr(2'b01, DSC_SW_RESET, 4'h0, 12'h000, 8'h00);
      chk(12'(output_hold), 12'h001);
      chk(12'(internal_reference_enable), 12'h000);
      u_dsc_host.pulse(1'b1);
      chk(12'(clear_active), 12'h002);
      chk(cc(4), 12'h000);
      tally_and_finish();
   end
endmodule // tb_top
